/* File: fss_pkg.sv */
// package: register map, field layout and constants of the format supervisor
package fss_pkg;

  // register offsets on the microcontroller register port
  localparam logic [7:0] REG_BUF_MODE   = 8'h53;
  localparam logic [7:0] REG_SYNC_LIMIT = 8'h70;
  localparam logic [7:0] REG_FMT_OP     = 8'h77;
  localparam logic [7:0] REG_START_ADDR = 8'h79;
  localparam logic [7:0] REG_FMT_STAT2  = 8'h7A;
  localparam logic [7:0] REG_SYNC_PATT  = 8'h7C;
  // control store window: bit 7 set, bits 6-5 pick the field, 4-0 the word
  localparam int         CS_BASE_BIT    = 7;

  // field positions
  localparam int BUF_PAR_EN_BIT  = 3;
  localparam int FMT_TWO_IDX_BIT = 6;
  localparam int STAT_PAR_BIT    = 6;
  localparam int STAT_TWO_IDX_BIT = 5;
  localparam int STAT_SYNC_TO_BIT = 4;
  localparam int CNT_START_BIT   = 5;

  // reset values
  localparam logic [7:0] BUF_MODE_RST   = 8'h00;
  localparam logic [7:0] SYNC_LIMIT_RST = 8'h00;
  localparam logic [7:0] FMT_OP_RST     = 8'h00;
  localparam logic [7:0] SYNC_PATT_RST  = 8'h00;
  localparam logic [31:0] WORD_RST      = 32'h0000_0000;

  // sequencer addressing
  localparam int         ADDR_W    = 5;
  localparam logic [4:0] STOP_ADDR = 5'h1F;

  // branch commands in next-address field bits 7-5
  localparam logic [2:0] BR_NEXT     = 3'h0;
  localparam logic [2:0] BR_DATA     = 3'h1;
  localparam logic [2:0] BR_PAR_STOP = 3'h5;

  // index pulses that end one revolution
  localparam logic [1:0] IDX_LIMIT = 2'h2;

endpackage

/* File: fss_sup_if.sv */
// interface: signals between the sequencer core and its supervision units
`timescale 1ns/100ps
`default_nettype none
interface fss_sup_if;
  logic       byte_tick;
  logic       word_start;
  logic       seq_reset;
  logic       sync_found;
  logic [7:0] sync_limit;
  logic       two_idx_en;
  logic       index_edge;
  logic       xfer_active;
  logic       timeout;
  logic       two_idx_flag;

  modport core (
    output byte_tick, word_start, seq_reset, sync_found, sync_limit,
    output two_idx_en, index_edge, xfer_active,
    input  timeout, two_idx_flag
  );
  modport sync_unit (
    input  byte_tick, word_start, seq_reset, sync_found, sync_limit,
    output timeout
  );
  modport idx_unit (
    input  word_start, two_idx_en, index_edge, xfer_active,
    output two_idx_flag
  );
endinterface
`default_nettype wire

/* File: fss_sync_timer.sv */
// synchronization timer: bounded search for the sync byte
`timescale 1ns/100ps
`default_nettype none
module fss_sync_timer
  import fss_pkg::*;
(
  // clocking
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic ce,
  // link to core
  fss_sup_if.sync_unit sup
);

  typedef struct packed {
    logic       active;
    logic [7:0] cnt;
    logic       timeout;
  } fss_st_type;

  fss_st_type s_q;
  fss_st_type s_d;

  // countdown of a private copy, limit register left intact
  always_comb begin
    s_d = s_q;
    s_d.timeout = 1'b0;
    if (sup.seq_reset || sup.sync_found) begin
      s_d.active = 1'b0; // [RULE_07]
    end else if (sup.word_start) begin
      s_d.active = 1'b1;          // [RULE_06]
      s_d.cnt    = sup.sync_limit; // [RULE_02] [RULE_18]
    end else if (s_q.active && sup.byte_tick) begin
      s_d.cnt = s_q.cnt - 8'h01; // [RULE_03]
      // a zero limit times out on the first byte time
      if (s_q.cnt <= 8'h01) begin
        s_d.active  = 1'b0;
        s_d.timeout = 1'b1; // [RULE_04]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign sup.timeout = s_q.timeout;

endmodule
`default_nettype wire

/* File: fss_index_counter.sv */
// revolution limit counter: counts index edges while armed
`timescale 1ns/100ps
`default_nettype none
module fss_index_counter
  import fss_pkg::*;
(
  // clocking
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic ce,
  // link to core
  fss_sup_if.idx_unit sup
);

  typedef struct packed {
    logic       armed;
    logic [1:0] edges;
    logic       flag;
  } fss_ic_type;

  fss_ic_type s_q;
  fss_ic_type s_d;

  // arm, count, disarm; flag lives until rearm or enable drop
  always_comb begin
    s_d = s_q;
    if (!sup.two_idx_en) begin
      s_d.armed = 1'b0; // [RULE_08] [RULE_10]
      s_d.flag  = 1'b0; // [RULE_12]
      s_d.edges = 2'h0;
    end else if (sup.word_start) begin
      s_d.armed = 1'b1; // [RULE_09]
      s_d.flag  = 1'b0; // [RULE_12]
      s_d.edges = 2'h0;
    end else if (s_q.armed && sup.xfer_active) begin
      s_d.armed = 1'b0; // [RULE_10]
    end else if (s_q.armed && sup.index_edge) begin
      s_d.edges = s_q.edges + 2'h1;
      if (s_q.edges + 2'h1 == IDX_LIMIT) begin
        s_d.armed = 1'b0; // [RULE_10]
        s_d.flag  = 1'b1; // [RULE_11]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign sup.two_idx_flag = s_q.flag;

endmodule
`default_nettype wire

/* File: fss_supervisor.sv */
// format sequencer core with sync, revolution and parity supervision
//
// Behaviour
// RULE_01 - sync timer limit is a 0..255 byte count from the limit register
// RULE_02 - one limit value serves every use of the sync timer
// RULE_03 - while active the timer counts down once per byte time
// RULE_04 - count reaching zero stops the sequencer and sets status bit 4
// RULE_05 - sync is found when an incoming byte equals the pattern register
// RULE_06 - a loaded word with count field bit 5 set starts the timer
// RULE_07 - sequencer reset or sync found resets the timer
// RULE_08 - revolution counter works only with operation control bit 6 set
// RULE_09 - with enable set, count field bit 5 arms the revolution counter
// RULE_10 - disarm on enable clear, second index pulse, or buffer transfer
// RULE_11 - two index edges while armed set status bit 5
// RULE_12 - status bit 5 holds until rearm or enable clear
// RULE_13 - buffer parity checked on NRZ writes and sector verify reads
// RULE_14 - parity enable bit 3 plus an error sets status bit 6
// RULE_15 - a branch command stops the sequencer on a parity error
// RULE_16 - writing start address fetches that word and executes it
// RULE_17 - fetching address 1FH stops the sequencer, also by start write
// RULE_18 - timer counts a working copy so the limit stays intact
`timescale 1ns/100ps
`default_nettype none
module fss_supervisor
  import fss_pkg::*;
#(
  parameter int CS_DEPTH = 32
)(
  // clocking
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        ce,
  // microcontroller register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // disk data path, same clock
  input  wire logic        byte_tick,
  input  wire logic [7:0]  nrz_byte,
  input  wire logic        xfer_active,
  input  wire logic        nrz_write,
  input  wire logic        verify_read,
  // buffer data at the formatter shifter
  input  wire logic [7:0]  buf_data,
  input  wire logic        buf_parity,
  input  wire logic        buf_valid,
  // index pulse pin, asynchronous
  input  wire logic        index_pin,
  // sequencer state
  output logic             seq_running,
  output logic      [31:0] seq_word,
  // error and status flags
  output logic             sync_timeout_err,
  output logic             two_index_det,
  output logic             parity_err
);

  // word field slices of the current word
  localparam int NEXT_HI = 31;
  localparam int CTRL_HI = 23;
  localparam int CNT_HI  = 15;
  localparam int DATA_HI = 7;

  typedef struct packed {
    logic [CS_DEPTH-1:0][31:0] cs;
    logic [7:0]        buf_mode;
    logic [7:0]        sync_limit;
    logic [7:0]        fmt_op;
    logic [7:0]        sync_patt;
    logic [31:0]       word;
    logic [ADDR_W-1:0] addr;
    logic              running;
    logic              word_start;
    logic              seq_reset;
    logic              sync_found;
    logic              byte_tick;
    logic              xfer;
    logic              par_err;
    logic              sync_to;
    logic              idx_s1;
    logic              idx_s2;
    logic              idx_prev;
    logic              idx_edge;
    logic [7:0]        rdata;
  } fss_core_type;

  fss_core_type s_q;
  fss_core_type s_d;

  fss_sup_if sup ();

  // odd parity across the byte and its parity bit
  logic par_bad;
  assign par_bad = ~(^{buf_data, buf_parity});

  // next word address chosen by the branch command
  function automatic logic [ADDR_W-1:0] next_addr(
    input logic [31:0] w,
    input logic        perr
  );
    logic [2:0] cmd;
    cmd = w[NEXT_HI -: 3];
    case (cmd)
      BR_DATA:     next_addr = w[DATA_HI - 3 -: ADDR_W];
      BR_PAR_STOP: next_addr = perr ? STOP_ADDR : w[NEXT_HI - 3 -: ADDR_W]; // [RULE_15]
      default:     next_addr = w[NEXT_HI - 3 -: ADDR_W];
    endcase
  endfunction

  // main next-state logic
  always_comb begin
    logic              load;
    logic [ADDR_W-1:0] load_addr;
    logic              clr_par;
    logic              clr_to;
    logic              set_par;
    load      = 1'b0;
    load_addr = STOP_ADDR;
    clr_par   = 1'b0;
    clr_to    = 1'b0;
    set_par   = 1'b0;
    s_d       = s_q;

    // event pulses last one cycle
    s_d.word_start = 1'b0;
    s_d.seq_reset  = 1'b0;

    // index pin through two flops before any edge logic
    s_d.idx_s1   = index_pin;
    s_d.idx_s2   = s_q.idx_s1;
    s_d.idx_prev = s_q.idx_s2;
    s_d.idx_edge = s_q.idx_s2 & ~s_q.idx_prev;

    // disk stream qualifiers for the supervision units
    s_d.byte_tick  = byte_tick & s_q.running;
    s_d.xfer       = xfer_active;
    s_d.sync_found = byte_tick && (nrz_byte == s_q.sync_patt); // [RULE_05]

    // register writes
    if (reg_wr) begin
      if (reg_addr[CS_BASE_BIT]) begin
        // control store byte: field picked by address bits 6-5
        case (reg_addr[6:5])
          2'h0:    s_d.cs[reg_addr[4:0]][31:24] = reg_wdata;
          2'h1:    s_d.cs[reg_addr[4:0]][23:16] = reg_wdata;
          2'h2:    s_d.cs[reg_addr[4:0]][15:8]  = reg_wdata;
          default: s_d.cs[reg_addr[4:0]][7:0]   = reg_wdata;
        endcase
      end else begin
        case (reg_addr)
          REG_BUF_MODE:   s_d.buf_mode   = reg_wdata;
          REG_SYNC_LIMIT: s_d.sync_limit = reg_wdata; // [RULE_01]
          REG_FMT_OP:     s_d.fmt_op     = reg_wdata;
          REG_SYNC_PATT:  s_d.sync_patt  = reg_wdata;
          REG_START_ADDR: begin
            load      = 1'b1; // [RULE_16]
            load_addr = reg_wdata[ADDR_W-1:0]; // [RULE_17]
          end
          REG_FMT_STAT2: begin
            // write one to clear the error bits
            clr_par = reg_wdata[STAT_PAR_BIT];
            clr_to  = reg_wdata[STAT_SYNC_TO_BIT];
          end
          default: ;
        endcase
      end
    end

    // parity check on writes and verify reads at the shifter
    if (buf_valid && (nrz_write || verify_read)) begin // [RULE_13]
      set_par = par_bad && s_q.buf_mode[BUF_PAR_EN_BIT]; // [RULE_14]
    end

    // sequencer stepping; a register load overrides the byte clock
    if (load) begin
      load = 1'b1;
    end else if (sup.timeout) begin
      load      = 1'b1;
      load_addr = STOP_ADDR; // [RULE_04]
    end else if (s_q.running && byte_tick) begin
      if (s_q.word[CNT_HI -: 8] == 8'h00) begin
        // count underflow fetches the next word
        load      = 1'b1;
        load_addr = next_addr(s_q.word, s_q.par_err | set_par);
      end else begin
        s_d.word[CNT_HI -: 8] = s_q.word[CNT_HI -: 8] - 8'h01;
      end
    end

    // fetch: the stop address halts instead of executing
    if (load) begin
      s_d.addr = load_addr;
      if (load_addr == STOP_ADDR) begin
        s_d.running   = 1'b0; // [RULE_17]
        s_d.seq_reset = 1'b1; // [RULE_07]
      end else begin
        s_d.running    = 1'b1; // [RULE_16]
        s_d.word       = s_q.cs[load_addr];
        s_d.word_start = s_q.cs[load_addr][CNT_HI - 8 + 1 + CNT_START_BIT]; // [RULE_06] [RULE_09]
      end
    end

    // sticky errors; a new event beats a clear in the same cycle
    s_d.par_err = (s_q.par_err & ~clr_par) | set_par; // [RULE_14]
    s_d.sync_to = (s_q.sync_to & ~clr_to) | sup.timeout; // [RULE_04]

    // registered read data
    if (reg_rd) begin
      if (reg_addr[CS_BASE_BIT]) begin
        case (reg_addr[6:5])
          2'h0:    s_d.rdata = s_q.cs[reg_addr[4:0]][31:24];
          2'h1:    s_d.rdata = s_q.cs[reg_addr[4:0]][23:16];
          2'h2:    s_d.rdata = s_q.cs[reg_addr[4:0]][15:8];
          default: s_d.rdata = s_q.cs[reg_addr[4:0]][7:0];
        endcase
      end else begin
        case (reg_addr)
          REG_BUF_MODE:   s_d.rdata = s_q.buf_mode;
          REG_SYNC_LIMIT: s_d.rdata = s_q.sync_limit;
          REG_FMT_OP:     s_d.rdata = s_q.fmt_op;
          REG_SYNC_PATT:  s_d.rdata = s_q.sync_patt;
          REG_START_ADDR: s_d.rdata = {3'h0, s_q.addr};
          REG_FMT_STAT2: begin
            s_d.rdata = 8'h00;
            s_d.rdata[STAT_PAR_BIT]     = s_q.par_err;
            s_d.rdata[STAT_TWO_IDX_BIT] = sup.two_idx_flag;
            s_d.rdata[STAT_SYNC_TO_BIT] = s_q.sync_to;
          end
          default:        s_d.rdata = 8'h00;
        endcase
      end
    end
  end

  // state register; clock enable freezes everything
  always_ff @(posedge clk) begin
    if (reset) begin
      s_q            <= '0;
      s_q.buf_mode   <= BUF_MODE_RST;
      s_q.sync_limit <= SYNC_LIMIT_RST;
      s_q.fmt_op     <= FMT_OP_RST;
      s_q.sync_patt  <= SYNC_PATT_RST;
      s_q.word       <= WORD_RST;
      s_q.addr       <= STOP_ADDR;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // drive the supervision interface from registered state
  assign sup.byte_tick   = s_q.byte_tick;
  assign sup.word_start  = s_q.word_start;
  assign sup.seq_reset   = s_q.seq_reset;
  assign sup.sync_found  = s_q.sync_found;
  assign sup.sync_limit  = s_q.sync_limit;
  assign sup.two_idx_en  = s_q.fmt_op[FMT_TWO_IDX_BIT]; // [RULE_08]
  assign sup.index_edge  = s_q.idx_edge;
  assign sup.xfer_active = s_q.xfer;

  fss_sync_timer u_sync (
    .clk   (clk),
    .reset (reset),
    .ce    (ce),
    .sup   (sup.sync_unit)
  );

  fss_index_counter u_idx (
    .clk   (clk),
    .reset (reset),
    .ce    (ce),
    .sup   (sup.idx_unit)
  );

  // outputs straight from flops
  assign reg_rdata        = s_q.rdata;
  assign seq_running      = s_q.running;
  assign seq_word         = s_q.word;
  assign sync_timeout_err = s_q.sync_to;
  assign two_index_det    = sup.two_idx_flag; // [RULE_11]
  assign parity_err       = s_q.par_err;

endmodule
`default_nettype wire

/* File: fss_disk_model.sv */
// disk channel model: byte times, nrz data and index pulses
`timescale 1ns/100ps
`default_nettype none
module fss_disk_model #(
  parameter int PERIOD = 8
)(
  // clocking
  input  wire logic       clk,
  // bench control
  input  wire logic       run_en,
  input  wire logic [7:0] sync_at,
  input  wire logic [7:0] pattern,
  input  wire logic       idx_req,
  // disk side
  output logic            byte_tick,
  output logic      [7:0] nrz_byte,
  output logic            index_pin,
  output logic      [7:0] tick_count
);
  int div;
  int idx_cnt;
  logic run_q;
  logic idx_q;

  // bench controls change on the falling edge, so take them on the rising one
  always @(posedge clk) begin
    run_q <= run_en;
    idx_q <= idx_req;
  end

  // start quiet; the data line is never left holding a value
  initial begin
    byte_tick = 1'b0;
    nrz_byte = 8'h00;
    index_pin = 1'b0;
    tick_count = 8'h00;
    div = 0;
    idx_cnt = 0;
    run_q = 1'b0;
    idx_q = 1'b0;
  end

  // one byte time per PERIOD cycles, data toggles between byte times
  always @(negedge clk) begin
    byte_tick <= 1'b0;
    nrz_byte  <= ~nrz_byte;
    if (!run_q) begin
      div        <= 0;
      tick_count <= 8'h00;
    end else if (div == PERIOD - 1) begin
      div        <= 0;
      byte_tick  <= 1'b1;
      tick_count <= tick_count + 8'h01;
      // filler equals the sync pattern only when tick_count equals pattern XOR 3CH
      nrz_byte   <= (tick_count + 8'h01 == sync_at) ? pattern : (8'h3C ^ tick_count);
    end else begin
      div <= div + 1;
    end
    // index pulse a few cycles wide so the synchroniser sees it
    if (idx_q) begin
      idx_cnt <= 4;
    end else if (idx_cnt != 0) begin
      idx_cnt <= idx_cnt - 1;
    end
    index_pin <= idx_q || (idx_cnt > 1);
  end
endmodule
`default_nettype wire

/* File: fss_supervisor_asserts.sv */
// checker: port-level properties of the format supervisor
`timescale 1ns/100ps
`default_nettype none
module fss_supervisor_asserts
  import fss_pkg::*;
#(
  parameter int CS_DEPTH = 32
)(
  // clocking
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        ce,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  // buffer side
  input wire logic        nrz_write,
  input wire logic        verify_read,
  input wire logic [7:0]  buf_data,
  input wire logic        buf_parity,
  input wire logic        buf_valid,
  // outputs watched
  input wire logic        seq_running,
  input wire logic [31:0] seq_word,
  input wire logic        sync_timeout_err,
  input wire logic        two_index_det,
  input wire logic        parity_err
);
  logic        par_en_q;
  logic        tidx_en_q;
  logic [7:0]  lim_q;
  logic [31:0] exp_q;
  logic [31:0] cs_m [CS_DEPTH];
  logic        wr;
  logic        bad_par;

  assign wr      = ce && reg_wr;
  // even count of ones over data and parity is an odd-parity fault
  assign bad_par = buf_valid && (nrz_write || verify_read) && par_en_q && !(^{buf_data, buf_parity});

  // mirror of the registers the properties depend on
  always_ff @(posedge clk) begin
    if (reset) begin
      par_en_q  <= 1'b0;
      tidx_en_q <= 1'b0;
      lim_q     <= 8'h00;
      exp_q     <= 32'h0000_0000;
      for (int i = 0; i < CS_DEPTH; i++) cs_m[i] <= 32'h0000_0000;
    end else if (wr) begin
      if (reg_addr == REG_BUF_MODE) par_en_q <= reg_wdata[BUF_PAR_EN_BIT];
      if (reg_addr == REG_FMT_OP) tidx_en_q <= reg_wdata[FMT_TWO_IDX_BIT];
      if (reg_addr == REG_SYNC_LIMIT) lim_q <= reg_wdata;
      if (reg_addr == REG_START_ADDR) exp_q <= cs_m[reg_wdata[4:0]];
      if (reg_addr[CS_BASE_BIT]) cs_m[reg_addr[4:0]][8 * (3 - int'(reg_addr[6:5])) +: 8] <= reg_wdata;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_lim_rd;
    ce && reg_rd && reg_addr == REG_SYNC_LIMIT |=> reg_rdata == $past(lim_q);
  endproperty
  a_lim_rd: assert property (p_lim_rd) else $error("limit readback differs");
  property p_start;
    wr && reg_addr == REG_START_ADDR && reg_wdata[4:0] != STOP_ADDR |=> seq_running && seq_word == exp_q;
  endproperty
  a_start: assert property (p_start) else $error("start did not load the word");
  property p_stop;
    wr && reg_addr == REG_START_ADDR && reg_wdata[4:0] == STOP_ADDR |=> !seq_running;
  endproperty
  a_stop: assert property (p_stop) else $error("stop address left sequencer running");
  property p_par_set;
    ce && bad_par |=> parity_err;
  endproperty
  a_par_set: assert property (p_par_set) else $error("parity fault not flagged");
  property p_par_cause;
    $rose(parity_err) |-> $past(bad_par);
  endproperty
  a_par_cause: assert property (p_par_cause) else $error("parity flag without a fault");
  property p_tidx_en;
    $rose(two_index_det) |-> tidx_en_q;
  endproperty
  a_tidx_en: assert property (p_tidx_en) else $error("revolution flag while disabled");
  property p_tidx_clr;
    wr && reg_addr == REG_FMT_OP && !reg_wdata[FMT_TWO_IDX_BIT] |-> ##2 !two_index_det;
  endproperty
  a_tidx_clr: assert property (p_tidx_clr) else $error("revolution flag kept after disable");
  property p_sync_stop;
    $rose(sync_timeout_err) |-> !seq_running;
  endproperty
  a_sync_stop: assert property (p_sync_stop) else $error("timeout did not stop sequencer");
endmodule

bind fss_supervisor fss_supervisor_asserts #(.CS_DEPTH(CS_DEPTH)) u_asserts (
  .clk, .reset, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .nrz_write, .verify_read,
  .buf_data, .buf_parity, .buf_valid, .seq_running, .seq_word, .sync_timeout_err, .two_index_det, .parity_err
);
`default_nettype wire

/* File: fss_supervisor_test.sv */
// testbench: self-checking scenarios for the format supervisor
`timescale 1ns/100ps
`default_nettype none
module fss_supervisor_test
  import fss_pkg::*;
;
  logic clk, reset, ce, reg_wr, reg_rd, xfer_active, nrz_write, verify_read, buf_parity, buf_valid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, nrz_byte, buf_data, sync_at, tick_count;
  logic byte_tick, index_pin, seq_running, sync_timeout_err, two_index_det, parity_err, run_en, idx_req;
  logic [31:0] seq_word;
  int fail_count = 0;
  int checks_done = 0;

  fss_supervisor #(.CS_DEPTH(32)) DUT (.clk, .reset, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .byte_tick, .nrz_byte, .xfer_active, .nrz_write, .verify_read, .buf_data, .buf_parity,
    .buf_valid, .index_pin, .seq_running, .seq_word, .sync_timeout_err, .two_index_det, .parity_err);
  fss_disk_model #(.PERIOD(8)) u_disk (.clk, .run_en, .sync_at, .pattern(8'hA1), .idx_req, .byte_tick,
    .nrz_byte, .index_pin, .tick_count);

  // 100 ns clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic give_verdict();
    if (fail_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    check({24'h0, reg_rdata}, {24'h0, exp});
  endtask

  task automatic cs_word(input logic [4:0] i, input logic [31:0] w);
    for (int f = 0; f < 4; f++) wr({1'b1, 2'(f), i}, w[8 * (3 - f) +: 8]);
  endtask

  // n byte times from the disk, then room for the pipeline to settle
  task automatic ticks(input int n);
    run_en = 1'b1;
    repeat (n * 8 + 5) @(negedge clk);
    run_en = 1'b0;
    // let the model see the pause so the next run starts a fresh byte time
    @(negedge clk);
  endtask

  task automatic idx_pair();
    repeat (2) begin
      idx_req = 1'b1;
      @(negedge clk);
      idx_req = 1'b0;
      repeat (12) @(negedge clk);
    end
  endtask

  task automatic buf_byte(input logic [7:0] d, input logic p, input logic exp);
    @(negedge clk);
    buf_data = d;
    buf_parity = p;
    buf_valid = 1'b1;
    @(negedge clk);
    buf_valid = 1'b0;
    @(negedge clk);
    check(parity_err, exp);
  endtask

  task automatic t_regs();
    rd_chk(REG_BUF_MODE, BUF_MODE_RST);
    rd_chk(REG_SYNC_LIMIT, SYNC_LIMIT_RST);
    rd_chk(REG_FMT_OP, FMT_OP_RST);
    rd_chk(REG_SYNC_PATT, SYNC_PATT_RST);
    rd_chk(REG_FMT_STAT2, 8'h00);
    wr(8'h71, 8'h55);
    rd_chk(8'h71, 8'h00);
    wr(REG_SYNC_LIMIT, 8'hFF);
    rd_chk(REG_SYNC_LIMIT, 8'hFF);
  endtask

  // same limit twice, then the shortest limit
  task automatic t_sync_timeout();
    logic [7:0] lim;
    wr(REG_SYNC_PATT, 8'hA1);
    cs_word(5'h02, 32'h0300_2000);
    for (int k = 0; k < 3; k++) begin
      lim = (k == 2) ? 8'h01 : 8'h03;
      if (k != 1) wr(REG_SYNC_LIMIT, lim);
      wr(REG_START_ADDR, 8'h02);
      check(seq_word, 32'h0300_2000);
      ticks(int'(lim) - 1);
      check(sync_timeout_err, 1'b0);
      ticks(1);
      check(sync_timeout_err, 1'b1);
      check(seq_running, 1'b0);
      rd_chk(REG_SYNC_LIMIT, lim);
      wr(REG_FMT_STAT2, 8'h10);
      check(sync_timeout_err, 1'b0);
    end
  endtask

  task automatic t_sync_found();
    wr(REG_SYNC_LIMIT, 8'h03);
    sync_at = 8'h02;
    wr(REG_START_ADDR, 8'h02);
    ticks(6);
    check(sync_timeout_err, 1'b0);
    check(seq_running, 1'b1);
    sync_at = 8'hFF;
    wr(REG_START_ADDR, 8'h1F);
    check(seq_running, 1'b0);
    rd_chk(REG_START_ADDR, 8'h1F);
    wr(REG_START_ADDR, 8'h02);
    ticks(2);
    wr(REG_START_ADDR, 8'h1F);
    // word without the start bit: only the stop may have cleared the timer
    wr(REG_START_ADDR, 8'h03);
    ticks(2);
    check(sync_timeout_err, 1'b0);
    wr(REG_START_ADDR, 8'h1F);
  endtask

  task automatic t_two_index();
    wr(REG_FMT_OP, 8'h40);
    wr(REG_START_ADDR, 8'h02);
    idx_pair();
    check(two_index_det, 1'b1);
    idx_pair();
    check(two_index_det, 1'b1);
    wr(REG_FMT_OP, 8'h00);
    @(negedge clk);
    check(two_index_det, 1'b0);
    wr(REG_START_ADDR, 8'h02);
    idx_pair();
    check(two_index_det, 1'b0);
    wr(REG_FMT_OP, 8'h40);
    wr(REG_START_ADDR, 8'h02);
    xfer_active = 1'b1;
    repeat (3) @(negedge clk);
    xfer_active = 1'b0;
    idx_pair();
    check(two_index_det, 1'b0);
    wr(REG_START_ADDR, 8'h02);
    idx_pair();
    check(two_index_det, 1'b1);
    wr(REG_START_ADDR, 8'h02);
    repeat (3) @(negedge clk);
    check(two_index_det, 1'b0);
    wr(REG_FMT_OP, 8'h00);
    wr(REG_START_ADDR, 8'h1F);
  endtask

  task automatic t_parity();
    wr(REG_BUF_MODE, 8'h08);
    nrz_write = 1'b1;
    buf_byte(8'h01, 1'b0, 1'b0);
    buf_byte(8'h01, 1'b1, 1'b1);
    cs_word(5'h06, {BR_PAR_STOP, 5'h07, 24'h00_0000});
    wr(REG_START_ADDR, 8'h06);
    ticks(1);
    check(seq_running, 1'b0);
    wr(REG_FMT_STAT2, 8'h40);
    wr(REG_START_ADDR, 8'h06);
    ticks(1);
    check(seq_running, 1'b1);
    rd_chk(REG_START_ADDR, 8'h07);
    nrz_write = 1'b0;
    buf_byte(8'h03, 1'b0, 1'b0);
    verify_read = 1'b1;
    buf_byte(8'h03, 1'b0, 1'b1);
    wr(REG_FMT_STAT2, 8'h40);
    wr(REG_BUF_MODE, 8'h00);
    buf_byte(8'h03, 1'b0, 1'b0);
    verify_read = 1'b0;
    // data branch takes its address from the data field, not the next field
    cs_word(5'h04, {BR_DATA, 5'h1E, 16'h0000, 8'h09});
    wr(REG_START_ADDR, 8'h04);
    ticks(1);
    rd_chk(REG_START_ADDR, 8'h09);
    wr(REG_START_ADDR, 8'h1F);
  endtask

  // the whole run takes a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    give_verdict();
  end

  // main sequence
  initial begin
    {reset, ce} = 2'b11;
    {reg_wr, reg_rd, xfer_active, nrz_write, verify_read, buf_parity, buf_valid, run_en, idx_req} = 9'h000;
    {reg_addr, reg_wdata, buf_data} = 24'h00_0000;
    sync_at = 8'hFF;
    repeat (6) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    t_regs();
    t_sync_timeout();
    t_sync_found();
    t_two_index();
    t_parity();
    give_verdict();
  end
endmodule
`default_nettype wire
